// ---- power_down_mode_control.sv ----
// Power-down mode controller: two control registers over AXI4-Lite,
// the operating-mode machine and the clock tick generators.
// Assumes sleep_exec and wake_irq are one-cycle pulses synchronous to
// aclk and that the timer watch select comes from the timer block.
`timescale 1ns/1ps

// Summary of operation
// - Wake wait field selects 8192..131072, 2, 8 or 16 states.
// - Interrupt exit from standby or watch to active waits first.
// - After watch, CPU runs on system clock or subclock per low speed bit.
// - First register bit 2 reads one, writes ignored.
// - Medium speed clock is oscillator over 16, 32, 64 or 128.
// - Second register bits 7 to 5 read one, writes ignored.
// - Noise sampling at oscillator over 16 or over 4.
// - Without direct transfer, sleep enters standby, watch, sleep, subsleep.
// - Direct transfer from high speed to medium speed or subactive.
// - Direct transfer from medium speed to high speed or subactive.
// - Direct transfer from subactive to high or medium speed.
// - After standby, watch or sleep, resume high or medium per select.
// - Subactive CPU clock is watch clock over 8, 4 or 2.
// - Subactive divider writes ignored while in subactive mode.
// - All select bits zero in active gives sleep high-speed.
// - Medium select alone in active gives sleep medium-speed.
// - Sleep medium entry may come half a state early.
// - Standby bit picks sleep or subsleep versus standby or watch.
// - From active, standby bit with timer watch bit picks watch, else standby; from subactive, standby bit alone picks watch.
module power_down_mode_control
    import power_down_pkg::*;
#(
    parameter int ADDR_W = 4,
    parameter int WAIT_000 = 8192,
    parameter int WAIT_001 = 16384,
    parameter int WAIT_010 = 32768,
    parameter int WAIT_011 = 65536,
    parameter int WAIT_100 = 131072
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic sleep_exec,
    input wire logic wake_irq,
    input wire logic timer_watch_select,
    input wire logic watch_tick,
    output mode_t mode,
    output logic cpu_halt,
    output logic cpu_on_subclock,
    output logic osc_running,
    output logic med_clk_tick,
    output logic sub_clk_tick,
    output logic noise_sample_tick
);

    // ==========================================================
    // Functions
    function automatic logic [CNT_W-1:0] wait_cycles(input logic [2:0] s);
        unique case (s)
            3'h0: wait_cycles = CNT_W'(WAIT_000);
            3'h1: wait_cycles = CNT_W'(WAIT_001);
            3'h2: wait_cycles = CNT_W'(WAIT_010);
            3'h3: wait_cycles = CNT_W'(WAIT_011);
            3'h4: wait_cycles = CNT_W'(WAIT_100);
            3'h5: wait_cycles = CNT_W'(WAIT_EXT_STATES);
            3'h6: wait_cycles = CNT_W'(WAIT_SHORT_STATES);
            3'h7: wait_cycles = CNT_W'(WAIT_MID_STATES);
        endcase
    endfunction

    function automatic logic [ADDR_W-1:0] word_of(input logic [ADDR_W-1:0] a);
        word_of = {a[ADDR_W-1:2], 2'h0};
    endfunction

    // ==========================================================
    // Registers
    logic [7:0] ctrl_one_q;
    logic [7:0] ctrl_two_q;
    mode_t mode_q, mode_d;
    logic [CNT_W-1:0] wait_cnt_q;

    wire logic software_standby_select = ctrl_one_q[STANDBY_SEL_BIT];
    wire logic [2:0] wait_sel = ctrl_one_q[WAIT_HI:WAIT_LO];
    wire logic low_speed_select = ctrl_one_q[LOW_SPEED_BIT];
    wire logic [1:0] medium_speed_divider = ctrl_one_q[MA_HI:MA_LO];
    wire logic noise_sample_rate_select = ctrl_two_q[NOISE_SEL_BIT];
    wire logic direct_transfer_select = ctrl_two_q[DIRECT_BIT];
    wire logic medium_speed_select = ctrl_two_q[MED_SEL_BIT];
    wire logic [1:0] subactive_clock_divider = ctrl_two_q[SA_HI:SA_LO];

    // ==========================================================
    // AXI4-Lite slave
    logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;

    wire logic aw_hs = s_axi_awvalid & awready_q;
    wire logic w_hs = s_axi_wvalid & wready_q;
    wire logic b_hs = bvalid_q & s_axi_bready;
    wire logic ar_hs = s_axi_arvalid & arready_q;
    wire logic r_hs = rvalid_q & s_axi_rready;
    wire logic do_write = ~awready_q & ~wready_q & ~bvalid_q;
    wire logic wr_one = word_of(awaddr_q) == OFS_CTRL_ONE;
    wire logic wr_two = word_of(awaddr_q) == OFS_CTRL_TWO;
    wire logic wr_ok = wr_one | wr_two;
    wire logic wr_lane = do_write & wstrb_q[0];
    wire logic rd_one = word_of(s_axi_araddr) == OFS_CTRL_ONE;
    wire logic rd_two = word_of(s_axi_araddr) == OFS_CTRL_TWO;
    wire logic [7:0] rd_byte = rd_one ? ctrl_one_q :
                               rd_two ? ctrl_two_q : 8'h00;

    // Fixed-one bits forced on every write
    wire logic [7:0] one_wr =
        (wdata_q[7:0] & ~CTRL_ONE_FIXED) | CTRL_ONE_FIXED;
    wire logic [7:0] two_raw =
        (wdata_q[7:0] & ~CTRL_TWO_FIXED) | CTRL_TWO_FIXED;
    wire logic in_subact = mode_q == MODE_SUBACT;
    wire logic [7:0] two_wr = in_subact ?
        {two_raw[7:SA_HI+1], ctrl_two_q[SA_HI:SA_LO]} : two_raw;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_q <= 1'b1;
            awaddr_q <= '0;
        end else if (aw_hs) begin
            awready_q <= 1'b0;
            awaddr_q <= s_axi_awaddr;
        end else if (b_hs) begin
            awready_q <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wready_q <= 1'b1;
            wdata_q <= '0;
            wstrb_q <= '0;
        end else if (w_hs) begin
            wready_q <= 1'b0;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
        end else if (b_hs) begin
            wready_q <= 1'b1;
        end
    end

    // Commits once both halves are in, whatever their order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (b_hs) begin
            bvalid_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rresp_q <= RESP_OKAY;
            rdata_q <= '0;
        end else if (ar_hs) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= {24'h000000, rd_byte};
            rresp_q <= (rd_one | rd_two) ? RESP_OKAY : RESP_SLVERR;
        end else if (r_hs) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_one_q <= CTRL_ONE_RESET;
            ctrl_two_q <= CTRL_TWO_RESET;
        end else begin
            if (wr_lane && wr_one)
                ctrl_one_q <= one_wr;
            if (wr_lane && wr_two)
                ctrl_two_q <= two_wr;
        end
    end

    // ==========================================================
    // Mode machine
    wire logic wait_done = wait_cnt_q == CNT_W'(1);
    // Direct transfer needs the exact select pattern, else normal sleep
    wire logic direct_hi_to_med = ~software_standby_select &
        medium_speed_select & ~low_speed_select;
    wire logic direct_med_to_hi = ~software_standby_select &
        ~medium_speed_select & ~low_speed_select;
    wire logic watch_pair = software_standby_select & timer_watch_select;
    wire logic direct_to_sub = watch_pair & low_speed_select;
    wire logic direct_sub_up = watch_pair & ~low_speed_select;
    wire mode_t resume_act = medium_speed_select ? MODE_ACT_MED
        : MODE_ACT_HIGH;
    // Sleep medium entry may land half a state early
    wire mode_t sleep_pick = medium_speed_select ? MODE_SLEEP_MED
        : MODE_SLEEP_HIGH;
    wire mode_t act_sleep = ~software_standby_select ? sleep_pick :
        timer_watch_select ? MODE_WATCH : MODE_STANDBY;
    wire mode_t sub_sleep = software_standby_select ? MODE_WATCH
        : MODE_SUBSLEEP;
    // Watch with the subclock selected skips the settling wait
    wire logic start_wait = wake_irq & ((mode_q == MODE_STANDBY) |
        ((mode_q == MODE_WATCH) & ~low_speed_select));

    always_comb begin
        mode_d = mode_q;
        unique case (mode_q)
            MODE_ACT_HIGH: if (sleep_exec) begin
                if (direct_transfer_select && direct_hi_to_med)
                    mode_d = MODE_ACT_MED;
                else if (direct_transfer_select && direct_to_sub)
                    mode_d = MODE_SUBACT;
                else
                    mode_d = act_sleep;
            end
            MODE_ACT_MED: if (sleep_exec) begin
                if (direct_transfer_select && direct_med_to_hi)
                    mode_d = MODE_ACT_HIGH;
                else if (direct_transfer_select && direct_to_sub)
                    mode_d = MODE_SUBACT;
                else
                    mode_d = act_sleep;
            end
            MODE_SUBACT: if (sleep_exec) begin
                if (direct_transfer_select && direct_sub_up)
                    mode_d = resume_act;
                else
                    mode_d = sub_sleep;
            end
            MODE_SLEEP_HIGH, MODE_SLEEP_MED: if (wake_irq)
                mode_d = resume_act;
            MODE_SUBSLEEP: if (wake_irq)
                mode_d = MODE_SUBACT;
            MODE_STANDBY: if (wake_irq)
                mode_d = MODE_WAKE_WAIT;
            MODE_WATCH: if (wake_irq)
                mode_d = low_speed_select ? MODE_SUBACT
                                          : MODE_WAKE_WAIT;
            MODE_WAKE_WAIT: if (wait_done)
                mode_d = resume_act;
            default: mode_d = MODE_ACT_HIGH;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_q <= MODE_ACT_HIGH;
            wait_cnt_q <= '0;
        end else begin
            mode_q <= mode_d;
            if (start_wait)
                wait_cnt_q <= wait_cycles(wait_sel);
            else if (mode_q == MODE_WAKE_WAIT && !wait_done)
                wait_cnt_q <= wait_cnt_q - CNT_W'(1);
        end
    end

    // ==========================================================
    // Clock ticks
    logic [6:0] med_cnt_q;
    logic [3:0] noise_cnt_q;
    logic [2:0] sub_cnt_q;
    logic med_tick_q, noise_tick_q, sub_tick_q;
    logic halt_q, on_sub_q, osc_q;

    wire logic [6:0] med_last =
        7'((MED_DIV_MIN << medium_speed_divider) - 1);
    wire logic [3:0] noise_last = noise_sample_rate_select ?
        4'(NOISE_DIV_FAST - 1) : 4'(NOISE_DIV_SLOW - 1);
    wire logic [2:0] sub_last = subactive_clock_divider[1] ?
        3'(SUB_DIV_FAST - 1) : subactive_clock_divider[0] ?
        3'(SUB_DIV_MID - 1) : 3'(SUB_DIV_SLOW - 1);
    wire logic med_mode = (mode_d == MODE_ACT_MED) |
                          (mode_d == MODE_SLEEP_MED);
    wire logic sub_mode = (mode_d == MODE_SUBACT) |
                          (mode_d == MODE_SUBSLEEP);
    wire logic run_mode = (mode_d == MODE_ACT_HIGH) |
                          (mode_d == MODE_ACT_MED) |
                          (mode_d == MODE_SUBACT);
    wire logic osc_on = ~((mode_d == MODE_STANDBY) |
                          (mode_d == MODE_WATCH) | sub_mode);
    wire logic med_hit = med_cnt_q >= med_last;
    wire logic noise_hit = noise_cnt_q >= noise_last;
    wire logic sub_hit = watch_tick & (sub_cnt_q >= sub_last);

    // Counters restart on mode entry, so the first tick is a full period
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            med_cnt_q <= '0;
            med_tick_q <= 1'b0;
        end else begin
            med_cnt_q <= (med_hit | ~med_mode) ? 7'h00 : med_cnt_q + 7'h01;
            med_tick_q <= med_mode & med_hit;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            noise_cnt_q <= '0;
            noise_tick_q <= 1'b0;
        end else begin
            noise_cnt_q <= (noise_hit | ~osc_on) ? 4'h0 : noise_cnt_q + 4'h1;
            noise_tick_q <= osc_on & noise_hit;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sub_cnt_q <= '0;
            sub_tick_q <= 1'b0;
        end else begin
            if (!sub_mode || sub_hit)
                sub_cnt_q <= 3'h0;
            else if (watch_tick)
                sub_cnt_q <= sub_cnt_q + 3'h1;
            sub_tick_q <= sub_mode & sub_hit;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            halt_q <= 1'b0;
            on_sub_q <= 1'b0;
            osc_q <= 1'b1;
        end else begin
            halt_q <= ~run_mode;
            on_sub_q <= sub_mode;
            osc_q <= osc_on;
        end
    end

    // ==========================================================
    // Outputs
    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign mode = mode_q;
    assign cpu_halt = halt_q;
    assign cpu_on_subclock = on_sub_q;
    assign osc_running = osc_q;
    assign med_clk_tick = med_tick_q;
    assign sub_clk_tick = sub_tick_q;
    assign noise_sample_tick = noise_tick_q;

endmodule // power_down_mode_control

// ---- power_down_pkg.sv ----
// Constants, field layout and mode codes of the power-down mode control.
// Assumes an AXI4-Lite master with 32-bit data and one clock domain.
package power_down_pkg;
    // ==========================================================
    // Register map
    localparam logic [3:0] OFS_CTRL_ONE = 4'h0;
    localparam logic [3:0] OFS_CTRL_TWO = 4'h4;
    localparam logic [7:0] CTRL_ONE_RESET = 8'h07;
    localparam logic [7:0] CTRL_TWO_RESET = 8'hf0;
    localparam logic [7:0] CTRL_ONE_FIXED = 8'h04;
    localparam logic [7:0] CTRL_TWO_FIXED = 8'he0;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    // ==========================================================
    // Field positions
    localparam int STANDBY_SEL_BIT = 7;
    localparam int WAIT_HI = 6;
    localparam int WAIT_LO = 4;
    localparam int LOW_SPEED_BIT = 3;
    localparam int MA_HI = 1;
    localparam int MA_LO = 0;
    localparam int NOISE_SEL_BIT = 4;
    localparam int DIRECT_BIT = 3;
    localparam int MED_SEL_BIT = 2;
    localparam int SA_HI = 1;
    localparam int SA_LO = 0;
    // ==========================================================
    // Timing
    localparam int CNT_W = 18;
    localparam int WAIT_EXT_STATES = 2;
    localparam int WAIT_SHORT_STATES = 8;
    localparam int WAIT_MID_STATES = 16;
    localparam int MED_DIV_MIN = 16;
    localparam int NOISE_DIV_SLOW = 16;
    localparam int NOISE_DIV_FAST = 4;
    localparam int SUB_DIV_SLOW = 8;
    localparam int SUB_DIV_MID = 4;
    localparam int SUB_DIV_FAST = 2;
    // ==========================================================
    // Operating modes
    typedef enum logic [8:0] {
        MODE_ACT_HIGH   = 9'h001,
        MODE_ACT_MED    = 9'h002,
        MODE_SUBACT     = 9'h004,
        MODE_SLEEP_HIGH = 9'h008,
        MODE_SLEEP_MED  = 9'h010,
        MODE_SUBSLEEP   = 9'h020,
        MODE_STANDBY    = 9'h040,
        MODE_WATCH      = 9'h080,
        MODE_WAKE_WAIT  = 9'h100
    } mode_t;
endpackage

// ---- power_down_asserts.sv ----
// Port checker for the power-down mode controller.
// Bound from the bench top; one clock, sync active-low reset.
`timescale 1ns/1ps
module power_down_asserts
    import power_down_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic wake_irq,
    input mode_t mode,
    input wire logic cpu_halt,
    input wire logic cpu_on_subclock,
    input wire logic osc_running,
    input wire logic med_clk_tick,
    input wire logic sub_clk_tick,
    input wire logic noise_sample_tick
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ==========================================================
    // Mode and flag relations
    a_halt_flag: assert property (
        cpu_halt == !(mode inside {MODE_ACT_HIGH, MODE_ACT_MED, MODE_SUBACT}))
        else $error("halt flag disagrees with mode");
    a_sub_flag: assert property (
        cpu_on_subclock == (mode inside {MODE_SUBACT, MODE_SUBSLEEP}))
        else $error("subclock flag disagrees with mode");
    a_osc_stop: assert property (
        mode inside {MODE_STANDBY, MODE_WATCH} |-> !osc_running)
        else $error("oscillator runs in standby or watch");
    a_sleep_wake: assert property (
        mode == MODE_SLEEP_HIGH && wake_irq |=> mode == MODE_ACT_HIGH)
        else $error("sleep high did not resume high speed");
    a_standby_wake: assert property (
        mode == MODE_STANDBY && wake_irq |=> mode == MODE_WAKE_WAIT)
        else $error("standby wake skipped the wait");
    a_wait_min: assert property (
        $rose(mode == MODE_WAKE_WAIT) |-> (mode == MODE_WAKE_WAIT) [*2])
        else $error("wake wait shorter than two states");
    a_wait_ends: assert property (
        $rose(mode == MODE_WAKE_WAIT)
        |-> ##[1:60] mode inside {MODE_ACT_HIGH, MODE_ACT_MED})
        else $error("wake wait did not expire");
    // ==========================================================
    // Tick spacing
    a_med_gap: assert property (
        med_clk_tick |=> !med_clk_tick [*8] ##1 !med_clk_tick [*7])
        else $error("medium tick faster than over 16");
    a_noise_gap: assert property (
        noise_sample_tick |=> !noise_sample_tick [*3])
        else $error("noise tick faster than over 4");
    a_sub_gap: assert property (
        sub_clk_tick |=> !sub_clk_tick [*5])
        else $error("subactive tick faster than two watch ticks");
    c_sleep_med: cover property (mode == MODE_SLEEP_MED);
    c_watch: cover property (mode == MODE_WATCH);
    c_wait_done: cover property ($fell(mode == MODE_WAKE_WAIT));
endmodule // power_down_asserts

// ---- sleep_irq_source.sv ----
// CPU and interrupt side: sleep pulses, wake pulses, timer watch bit,
// and a free-running watch clock tick every third aclk.
`timescale 1ns/1ps
module sleep_irq_source (
    input wire logic aclk,
    input wire logic aresetn,
    output logic sleep_exec,
    output logic wake_irq,
    output logic timer_watch_select,
    output logic watch_tick
);
    logic [1:0] wdiv_q;
    initial begin
        sleep_exec = 1'b0;
        wake_irq = 1'b0;
        timer_watch_select = 1'b0;
    end
    // Watch clock keeps running in every mode
    always_ff @(posedge aclk) begin
        if (!aresetn) wdiv_q <= 2'h0;
        else wdiv_q <= (wdiv_q == 2'h2) ? 2'h0 : wdiv_q + 2'h1;
    end
    assign watch_tick = (wdiv_q == 2'h2);
    task pulse_sleep;
        @(posedge aclk) sleep_exec <= 1'b1;
        @(posedge aclk) sleep_exec <= 1'b0;
    endtask
    // Request already filtered by the interrupt enables
    task pulse_wake;
        @(posedge aclk) wake_irq <= 1'b1;
        @(posedge aclk) wake_irq <= 1'b0;
    endtask
    task set_watch(input logic b);
        @(posedge aclk) timer_watch_select <= b;
    endtask
endmodule // sleep_irq_source

// ---- power_down_mode_control_bench.sv ----
// Self-checking bench: AXI4-Lite register tasks plus sleep/wake traffic.
// Wake waits shortened by parameter; watch tick every third aclk.
`timescale 1ns/1ps
module power_down_mode_control_bench;
    import power_down_pkg::*;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid;
    logic [3:0] awaddr, araddr, wstrb;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    logic sleep_exec, wake_irq, twsel, watch_tick;
    logic cpu_halt, on_sub, osc_on, med_tick, sub_tick, noise_tick;
    mode_t mode;
    int fails, checked, p, i;
    int wt[8] = '{20, 24, 28, 32, 40, 2, 8, 16};
    int sd[4] = '{8, 4, 2, 2};
    power_down_mode_control #(.WAIT_000(20), .WAIT_001(24), .WAIT_010(28),
        .WAIT_011(32), .WAIT_100(40)) power_down_mode_control_i (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .sleep_exec(sleep_exec), .wake_irq(wake_irq),
        .timer_watch_select(twsel), .watch_tick(watch_tick), .mode(mode),
        .cpu_halt(cpu_halt), .cpu_on_subclock(on_sub),
        .osc_running(osc_on), .med_clk_tick(med_tick),
        .sub_clk_tick(sub_tick), .noise_sample_tick(noise_tick));
    sleep_irq_source sleep_irq_source_i (.aclk(aclk), .aresetn(aresetn),
        .sleep_exec(sleep_exec), .wake_irq(wake_irq),
        .timer_watch_select(twsel), .watch_tick(watch_tick));
    // ==========================================================
    // Reporting
    task close_out;
        $display("checked=%0d fails=%0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task chk_mode(input mode_t exp);
        #1;
        chk({23'h0, mode}, {23'h0, exp});
    endtask
    task tmo(input int k);
        if (k >= 2000) begin
            fails++;
            close_out();
        end
    endtask
    // ==========================================================
    // AXI4-Lite master
    task wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] er);
        int k;
        @(posedge aclk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= {24'h0, d};
        wvalid <= 1'b1;
        bready <= 1'b1;
        k = 0;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            k++;
        end while (!bvalid && k < 2000);
        bready <= 1'b0;
        tmo(k);
        chk(bresp, er);
    endtask
    task rd(input logic [3:0] a, input logic [7:0] d, input logic [1:0] er);
        int k;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        k = 0;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            k++;
        end while (!rvalid && k < 2000);
        rready <= 1'b0;
        tmo(k);
        chk(rdata, {24'h0, d});
        chk(rresp, er);
    endtask
    // ==========================================================
    // Tick period and wake wait measurement
    function automatic logic tk(input int w);
        return w == 0 ? med_tick : (w == 1 ? sub_tick : noise_tick);
    endfunction
    task period(input int w, output int n);
        int k;
        k = 0;
        do begin @(posedge aclk); k++; end while (!tk(w) && k < 2000);
        n = 0;
        do begin @(posedge aclk); n++; end while (!tk(w) && n < 2000);
        tmo(k);
        tmo(n);
    endtask
    task wake_wait(output int n);
        sleep_irq_source_i.pulse_wake();
        n = 0;
        do begin
            @(posedge aclk);
            if (mode === MODE_WAKE_WAIT) n++;
        end while (mode === MODE_WAKE_WAIT && n < 2000);
        tmo(n);
    endtask
    // ==========================================================
    // Clock, timeout, main sequence
    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end
    initial begin
        #2ms;
        fails++;
        close_out();
    end
    initial begin
        fails = 0;
        checked = 0;
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
        awaddr = 4'h0;
        araddr = 4'h0;
        wdata = 32'h0;
        wstrb = 4'hf;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rd(OFS_CTRL_ONE, CTRL_ONE_RESET, RESP_OKAY);
        rd(OFS_CTRL_TWO, CTRL_TWO_RESET, RESP_OKAY);
        period(2, p);
        chk(p, NOISE_DIV_FAST);
        wr(OFS_CTRL_ONE, 8'h00, RESP_OKAY);
        rd(OFS_CTRL_ONE, CTRL_ONE_FIXED, RESP_OKAY);
        wstrb <= 4'he;
        wr(OFS_CTRL_ONE, 8'hff, RESP_OKAY);
        rd(OFS_CTRL_ONE, CTRL_ONE_FIXED, RESP_OKAY);
        wstrb <= 4'hf;
        wr(OFS_CTRL_TWO, 8'h00, RESP_OKAY);
        rd(OFS_CTRL_TWO, CTRL_TWO_FIXED, RESP_OKAY);
        period(2, p);
        chk(p, NOISE_DIV_SLOW);
        rd(4'h8, 8'h00, RESP_SLVERR);
        wr(4'hc, 8'hff, RESP_SLVERR);
        sleep_irq_source_i.pulse_sleep();
        chk_mode(MODE_SLEEP_HIGH);
        chk(cpu_halt, 1'b1);
        sleep_irq_source_i.pulse_wake();
        chk_mode(MODE_ACT_HIGH);
        for (i = 0; i < 4; i++) begin
            wr(OFS_CTRL_ONE, 8'(i), RESP_OKAY);
            wr(OFS_CTRL_TWO, 8'h04, RESP_OKAY);
            sleep_irq_source_i.pulse_sleep();
            chk_mode(MODE_SLEEP_MED);
            period(0, p);
            chk(p, MED_DIV_MIN << i);
            sleep_irq_source_i.pulse_wake();
            chk_mode(MODE_ACT_MED);
            wr(OFS_CTRL_TWO, 8'h08, RESP_OKAY);
            sleep_irq_source_i.pulse_sleep();
            chk_mode(MODE_ACT_HIGH);
        end
        wr(OFS_CTRL_TWO, 8'h0c, RESP_OKAY);
        sleep_irq_source_i.pulse_sleep();
        chk_mode(MODE_ACT_MED);
        wr(OFS_CTRL_TWO, 8'h08, RESP_OKAY);
        sleep_irq_source_i.pulse_sleep();
        chk_mode(MODE_ACT_HIGH);
        wr(OFS_CTRL_TWO, 8'h00, RESP_OKAY);
        for (i = 0; i < 8; i++) begin
            wr(OFS_CTRL_ONE, {1'b1, 3'(i), 4'h0}, RESP_OKAY);
            sleep_irq_source_i.pulse_sleep();
            chk_mode(MODE_STANDBY);
            chk(osc_on, 1'b0);
            wake_wait(p);
            chk(p, wt[i]);
            chk_mode(MODE_ACT_HIGH);
        end
        sleep_irq_source_i.set_watch(1'b1);
        sleep_irq_source_i.pulse_sleep();
        chk_mode(MODE_WATCH);
        wake_wait(p);
        chk(p, wt[7]);
        for (i = 0; i < 4; i++) begin
            wr(OFS_CTRL_ONE, 8'h88, RESP_OKAY);
            wr(OFS_CTRL_TWO, 8'h08 | 8'(i), RESP_OKAY);
            sleep_irq_source_i.pulse_sleep();
            chk_mode(MODE_SUBACT);
            period(1, p);
            chk(p, 3 * sd[i]);
            wr(OFS_CTRL_TWO, 8'h08 | 8'(3 - i), RESP_OKAY);
            rd(OFS_CTRL_TWO, 8'he8 | 8'(i), RESP_OKAY);
            wr(OFS_CTRL_ONE, 8'h80, RESP_OKAY);
            sleep_irq_source_i.pulse_sleep();
            chk_mode(MODE_ACT_HIGH);
        end
        wr(OFS_CTRL_ONE, 8'h88, RESP_OKAY);
        wr(OFS_CTRL_TWO, 8'h00, RESP_OKAY);
        sleep_irq_source_i.pulse_sleep();
        chk_mode(MODE_WATCH);
        sleep_irq_source_i.pulse_wake();
        chk_mode(MODE_SUBACT);
        chk(on_sub, 1'b1);
        wr(OFS_CTRL_ONE, 8'h08, RESP_OKAY);
        sleep_irq_source_i.pulse_sleep();
        chk_mode(MODE_SUBSLEEP);
        sleep_irq_source_i.pulse_wake();
        chk_mode(MODE_SUBACT);
        close_out();
    end
endmodule // power_down_mode_control_bench

bind power_down_mode_control power_down_asserts power_down_asserts_i (
    .aclk(aclk), .aresetn(aresetn), .wake_irq(wake_irq), .mode(mode),
    .cpu_halt(cpu_halt), .cpu_on_subclock(cpu_on_subclock),
    .osc_running(osc_running), .med_clk_tick(med_clk_tick),
    .sub_clk_tick(sub_clk_tick), .noise_sample_tick(noise_sample_tick));
